// ---- sec_regs.svh ----
// constants of the serial eeprom command engine
// assumes inclusion by bare name from design and bench
`ifndef SEC_REGS_SVH
`define SEC_REGS_SVH
`define SEC_OP_WRITE 8'h02
`define SEC_OP_READ 8'h03
`define SEC_OP_CLR 8'h04
`define SEC_OP_SET 8'h06
`define SEC_OP_SRD 8'h05
`define SEC_OP_SWR 8'h01
`define SEC_SR_PPE 7
`define SEC_SR_BPH 3
`define SEC_SR_BPL 2
`define SEC_SR_LATCH 1
`define SEC_SR_BUSY 0
`define SEC_SR_PPE_RESET 1'h0
`define SEC_SR_BP_RESET 2'h0
`define SEC_CLK_HZ 20000000
`define SEC_PROG_TIME_MS 5
`define SEC_PROG_CYCLES (`SEC_PROG_TIME_MS * (`SEC_CLK_HZ / 1000))
`define SEC_MEM_BYTES 8192
`define SEC_PAGE_BYTES 32
`define SEC_FIFO_DEPTH 8
`endif

// ---- sec_pkg.sv ----
// types of the serial eeprom command engine
// assumes sec_regs.svh is on the include path
package sec_pkg;
  typedef enum logic [2:0] {
    ST_OPC, ST_ADDR, ST_RD, ST_WR, ST_SRR, ST_SRW, ST_DONE, ST_IGNORE
  } sec_state_e;
  typedef logic [12:0] sec_addr_t;
  typedef logic [7:0] sec_byte_t;
endpackage

// ---- sec_spi_eeprom.sv ----
// serial eeprom command engine with page buffer and data fifo
// assumes pins arrive asynchronous to clk and sck is much slower than clk
//
// Contract
// [RULE1] eight-bit opcode register, input bits taken on sck rising edges
// [RULE2] host keeps select low and pause high through each command
// [RULE3] opcode, address and data shift most significant first
// [RULE4] first command bit is the first rise after select falls
// [RULE5] pause freezes the sequence, release resumes at the same bit
// [RULE6] opcode 03h reads the array, 02h writes the array
// [RULE7] opcode 06h sets the write latch, 04h clears it
// [RULE8] opcode 05h reads status, 01h writes status
// [RULE9] read is opcode, sixteen-bit address, top three ignored, then data
// [RULE10] read pointer steps after each byte and wraps 1FFFh to 0000h
// [RULE11] raising select ends a read and stops output
// [RULE12] latch sets only on select rise right after the set opcode
// [RULE13] write is opcode, address, then one to 32 bytes in a page
// [RULE14] write address wraps inside its page, never to the next page
// [RULE15] programming starts only on select rise after a whole byte
// [RULE16] array reads refused while programming, status reads always served
// [RULE17] programming completion clears the write latch
// [RULE18] latch cleared at reset and after clear, status or array write
// [RULE19] status: bit7 pin protect, bits3-2 block protect, latch, busy
// [RULE20] busy flag reads one while programming, writes to it ignored
// [RULE21] latch flag mirrors latch, set and clear ignore status protection
// [RULE22] block protect changes only by status write and is kept
// [RULE23] status read repeats the current status until select rises
// [RULE24] block protect selects none, upper quarter, upper half or all
// [RULE25] protect pin low with pin protect set refuses status writes
// [RULE26] programming lasts the programming time from the select rise
// [RULE27] output changes after sck falls, released when deselected or paused
// [RULE28] unknown opcode does nothing and input is ignored until deselect
`timescale 1ns/100ps
`include "sec_regs.svh"

module sec_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = `SEC_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic full;
  logic empty;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  assign empty = (wr_q == rd_q);
  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

module sec_spi_eeprom
  import sec_pkg::*;
#(
  parameter int PROG_CYCLES = `SEC_PROG_CYCLES,
  parameter int FIFO_DEPTH = `SEC_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so_out,
  output logic so_oe_n
);
  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam logic [4:0] SYNC_INIT = 5'h19;
  logic [4:0] pins;
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic sck_prev_q;
  logic cs_prev_q;
  logic sel;
  logic sck_s;
  logic si_s;
  logic hold_s;
  logic wp_s;
  logic rise;
  logic fall;
  logic cs_rise;
  sec_state_e state_q;
  logic [3:0] cnt_q;
  logic [15:0] sh_q;
  sec_byte_t op_q;
  sec_byte_t byte_in;
  sec_addr_t addr_new;
  sec_addr_t ptr_q;
  sec_addr_t rd_ptr_q;
  logic byte_end;
  logic addr_done;
  logic wr_any_q;
  logic wr_bad_q;
  sec_byte_t sr_new_q;
  sec_byte_t out_sr_q;
  logic [2:0] ocnt_q;
  logic so_q;
  logic latch_q;
  logic ppe_q;
  logic [1:0] bp_q;
  logic busy_q;
  logic kind_q;
  logic commit_q;
  logic [TW-1:0] tmr_q;
  sec_byte_t status;
  logic prog_done;
  logic set_ev;
  logic clr_ev;
  logic sr_try;
  logic sr_ev;
  logic arr_ev;
  logic push_valid;
  logic push_rdy;
  logic pop_valid;
  logic pop_rdy;
  logic [12:0] pop_data;
  logic [7:0] page_q;
  logic prot;
  sec_byte_t mem_q [`SEC_MEM_BYTES];
  sec_byte_t pg_q [`SEC_PAGE_BYTES];
  logic [`SEC_PAGE_BYTES-1:0] dirty_q;

  if (PROG_CYCLES < 2 || FIFO_DEPTH < 2) begin : g_bad_param
    $error("programming count and fifo depth must be at least two");
  end

  // two-stage synchronisers
  assign pins = {wp_n, hold_n, si, sck, cs_n};
  for (genvar i = 0; i < 5; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (rst) begin
        meta_q[i] <= SYNC_INIT[i];
        sync_q[i] <= SYNC_INIT[i];
      end else begin
        meta_q[i] <= pins[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign sel = !sync_q[0];
  assign sck_s = sync_q[1];
  assign si_s = sync_q[2];
  assign hold_s = sync_q[3];
  assign wp_s = sync_q[4];

  always_ff @(posedge clk) begin
    if (rst) begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      cs_prev_q <= sync_q[0];
    end
  end

  // edges count only while selected and not paused
  // [RULE5] pause masks edges
  // [RULE2] host keeps pause high
  assign rise = sel && hold_s && sck_s && !sck_prev_q;
  assign fall = sel && hold_s && !sck_s && sck_prev_q;
  assign cs_rise = sync_q[0] && !cs_prev_q;

  // [RULE3] msb first shift
  assign byte_in = {sh_q[6:0], si_s};
  assign addr_new = {sh_q[11:0], si_s};
  assign byte_end = rise && (cnt_q[2:0] == 3'h7);
  assign addr_done = rise && (state_q == ST_ADDR) && (cnt_q == 4'hF);

  // command engine
  // [RULE1] opcode capture on rise
  // [RULE4] engine restarts on select
  always_ff @(posedge clk) begin
    if (rst || !sel) begin
      state_q <= ST_OPC;
      cnt_q <= 4'h0;
      sh_q <= 16'h0000;
      wr_any_q <= 1'b0;
      wr_bad_q <= 1'b0;
    end else if (rise) begin
      sh_q <= {sh_q[14:0], si_s};
      cnt_q <= cnt_q + 4'h1;
      case (state_q)
        ST_OPC: begin
          if (byte_end) begin
            cnt_q <= 4'h0;
            // [RULE6] array opcode decode
            // [RULE7] latch opcode decode
            // [RULE8] status opcode decode
            // [RULE16] read refused while busy
            // [RULE28] unknown opcode ignored
            case (byte_in)
              `SEC_OP_READ: state_q <= busy_q ? ST_IGNORE : ST_ADDR;
              `SEC_OP_WRITE: begin
                state_q <= (busy_q || !latch_q) ? ST_IGNORE : ST_ADDR;
              end
              `SEC_OP_SET: state_q <= ST_DONE;
              `SEC_OP_CLR: state_q <= ST_DONE;
              `SEC_OP_SRD: state_q <= ST_SRR;
              `SEC_OP_SWR: state_q <= ST_SRW;
              default: state_q <= ST_IGNORE;
            endcase
          end
        end
        ST_ADDR: begin
          // [RULE9] sixteen address bits
          if (cnt_q == 4'hF) begin
            cnt_q <= 4'h0;
            wr_any_q <= 1'b0;
            wr_bad_q <= 1'b0;
            state_q <= (op_q == `SEC_OP_READ) ? ST_RD : ST_WR;
          end
        end
        ST_WR: begin
          // [RULE13] collect page bytes
          if (byte_end) begin
            cnt_q <= 4'h0;
            wr_any_q <= 1'b1;
            if (!push_rdy) begin
              wr_bad_q <= 1'b1;
            end
          end
        end
        ST_SRW: begin
          if (byte_end) begin
            cnt_q <= 4'h0;
            state_q <= ST_DONE;
          end
        end
        ST_DONE: state_q <= ST_IGNORE;
        default: cnt_q <= 4'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      op_q <= 8'h00;
      sr_new_q <= 8'h00;
    end else if (byte_end && state_q == ST_OPC) begin
      op_q <= byte_in;
    end else if (byte_end && state_q == ST_SRW) begin
      sr_new_q <= byte_in;
    end
  end

  // write pointer, upper bits ignored
  // [RULE14] wrap within page
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_q <= 13'h0000;
      page_q <= 8'h00;
    end else if (addr_done) begin
      ptr_q <= addr_new;
      page_q <= addr_new[12:5];
    end else if (push_valid) begin
      ptr_q <= {ptr_q[12:5], 5'(ptr_q[4:0] + 5'h01)};
    end
  end

  assign push_valid = byte_end && (state_q == ST_WR);
  assign pop_rdy = !busy_q;

  sec_fifo #(
    .WIDTH(13),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(push_rdy),
    .in_data({ptr_q[4:0], byte_in}),
    .out_valid(pop_valid),
    .out_ready(pop_rdy),
    .out_data(pop_data)
  );

  // page buffer fed by the fifo
  always_ff @(posedge clk) begin
    if (rst || prog_done) begin
      dirty_q <= '0;
    end else if (addr_done && op_q == `SEC_OP_WRITE) begin
      dirty_q <= '0;
    end else if (pop_valid && pop_rdy) begin
      dirty_q[pop_data[12:8]] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (pop_valid && pop_rdy) begin
      pg_q[pop_data[12:8]] <= pop_data[7:0];
    end
  end

  // [RULE19] status layout
  // [RULE20] busy flag read only
  // [RULE21] latch flag mirror
  always_comb begin
    status = 8'h00;
    status[`SEC_SR_PPE] = ppe_q;
    status[`SEC_SR_BPH] = bp_q[1];
    status[`SEC_SR_BPL] = bp_q[0];
    status[`SEC_SR_LATCH] = latch_q;
    status[`SEC_SR_BUSY] = busy_q;
  end

  // data output, shifted on falling sck
  // [RULE10] pointer step and wrap
  // [RULE23] status repeats live
  // [RULE27] output after fall
  always_ff @(posedge clk) begin
    if (rst || !sel) begin
      out_sr_q <= 8'h00;
      ocnt_q <= 3'h0;
      so_q <= 1'b0;
      rd_ptr_q <= 13'h0000;
    end else if (addr_done && op_q == `SEC_OP_READ) begin
      out_sr_q <= mem_q[addr_new];
      rd_ptr_q <= 13'(addr_new + 13'h0001);
      ocnt_q <= 3'h0;
    end else if (byte_end && state_q == ST_OPC && byte_in == `SEC_OP_SRD) begin
      out_sr_q <= status;
      ocnt_q <= 3'h0;
    end else if (fall && (state_q == ST_RD || state_q == ST_SRR)) begin
      so_q <= out_sr_q[7];
      ocnt_q <= ocnt_q + 3'h1;
      if (ocnt_q != 3'h7) begin
        out_sr_q <= {out_sr_q[6:0], 1'b0};
      end else if (state_q == ST_RD) begin
        out_sr_q <= mem_q[rd_ptr_q];
        rd_ptr_q <= 13'(rd_ptr_q + 13'h0001);
      end else begin
        out_sr_q <= status;
      end
    end
  end

  // [RULE11] deselect releases output
  assign so_out = so_q;
  assign so_oe_n = !(sel && hold_s && (state_q == ST_RD || state_q == ST_SRR));

  // events on the rising select
  // [RULE12] latch set on deselect
  // [RULE15] commit only byte aligned
  // [RULE25] pin protect on status
  assign set_ev = cs_rise && state_q == ST_DONE && op_q == `SEC_OP_SET;
  assign clr_ev = cs_rise && state_q == ST_DONE && op_q == `SEC_OP_CLR;
  assign sr_try = cs_rise && state_q == ST_DONE && op_q == `SEC_OP_SWR;
  assign sr_ev = sr_try && latch_q && !busy_q && !(ppe_q && !wp_s);
  assign arr_ev = cs_rise && state_q == ST_WR && cnt_q == 4'h0 &&
                  wr_any_q && !wr_bad_q && !busy_q;

  // programming timer
  // [RULE26] programming time count
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      kind_q <= 1'b0;
      commit_q <= 1'b0;
      tmr_q <= '0;
    end else if (sr_ev) begin
      busy_q <= 1'b1;
      kind_q <= 1'b1;
      tmr_q <= TW'(PROG_CYCLES - 1);
    end else if (arr_ev) begin
      commit_q <= 1'b1;
      kind_q <= 1'b0;
    end else if (commit_q && !pop_valid) begin
      commit_q <= 1'b0;
      busy_q <= 1'b1;
      tmr_q <= TW'(PROG_CYCLES - 1);
    end else if (busy_q) begin
      if (tmr_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        tmr_q <= tmr_q - 1'b1;
      end
    end
  end

  assign prog_done = busy_q && (tmr_q == '0);

  // [RULE17] clear at completion
  // [RULE18] latch clear sources
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_q <= 1'b0;
    end else if (set_ev) begin
      latch_q <= 1'b1;
    end else if (clr_ev || prog_done) begin
      latch_q <= 1'b0;
    end
  end

  // [RULE22] protect bits by status write
  always_ff @(posedge clk) begin
    if (rst) begin
      ppe_q <= `SEC_SR_PPE_RESET;
      bp_q <= `SEC_SR_BP_RESET;
    end else if (prog_done && kind_q) begin
      ppe_q <= sr_new_q[`SEC_SR_PPE];
      bp_q <= {sr_new_q[`SEC_SR_BPH], sr_new_q[`SEC_SR_BPL]};
    end
  end

  // [RULE24] block protect ranges
  assign prot = (bp_q == 2'h3) || (bp_q == 2'h2 && page_q[7]) ||
                (bp_q == 2'h1 && page_q[7:6] == 2'h3);

  always_ff @(posedge clk) begin
    if (prog_done && !kind_q && !prot) begin
      for (int i = 0; i < `SEC_PAGE_BYTES; i++) begin
        if (dirty_q[i]) begin
          mem_q[{page_q, 5'(i)}] <= pg_q[i];
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_read_opc;
    byte_end && state_q == ST_OPC && byte_in == `SEC_OP_READ;
  endsequence
  sequence s_deselect;
    cs_rise ##1 so_oe_n [*2];
  endsequence

  property p_read_go;
    s_read_opc ##0 !busy_q |=> state_q == ST_ADDR;
  endproperty
  a_read_go: assert property (p_read_go) // [RULE6]
    else $error("read opcode not decoded");

  property p_read_refuse;
    s_read_opc ##0 busy_q |=> state_q == ST_IGNORE;
  endproperty
  a_read_refuse: assert property (p_read_refuse) // [RULE16]
    else $error("array read served while busy");

  property p_prog_start;
    $rose(busy_q) |-> tmr_q == TW'(PROG_CYCLES - 1);
  endproperty
  a_prog_start: assert property (p_prog_start) // [RULE26]
    else $error("programming timer loaded wrong");

  property p_prog_latch;
    prog_done && !set_ev |=> !latch_q && !busy_q;
  endproperty
  a_prog_latch: assert property (p_prog_latch) // [RULE17]
    else $error("latch or busy left after programming");

  property p_set_latch;
    set_ev |=> latch_q ##1 latch_q;
  endproperty
  a_set_latch: assert property (p_set_latch) // [RULE12]
    else $error("latch not set on deselect");

  property p_page_wrap;
    push_valid && ptr_q[4:0] == 5'h1F |=>
      ptr_q[4:0] == 5'h00 && $stable(ptr_q[12:5]);
  endproperty
  a_page_wrap: assert property (p_page_wrap) // [RULE14]
    else $error("write pointer left the page");

  property p_hold_frz;
    sel && !hold_s |=> $stable(cnt_q) && $stable(sh_q);
  endproperty
  a_hold_frz: assert property (p_hold_frz) // [RULE5]
    else $error("sequence moved while paused");

  property p_oe_off;
    cs_rise |-> s_deselect;
  endproperty
  a_oe_off: assert property (p_oe_off) // [RULE27]
    else $error("output driven after deselect");

  property p_sr_wp;
    sr_try && ppe_q && !wp_s && !busy_q |=> !busy_q;
  endproperty
  a_sr_wp: assert property (p_sr_wp) // [RULE25]
    else $error("protected status write accepted");

  property p_rd_wrap;
    fall && state_q == ST_RD && ocnt_q == 3'h7 && rd_ptr_q == 13'h1FFF
      |=> rd_ptr_q == 13'h0000;
  endproperty
  a_rd_wrap: assert property (p_rd_wrap) // [RULE10]
    else $error("read pointer did not wrap");
endmodule

// ---- sec_host.sv ----
// spi host model driving the eeprom pins in mode 0, 400 ns sck
// assumes a 50 ns clk; the bench calls its tasks in sequence
`timescale 1ns/100ps
module sec_host (
  input wire logic clk,
  input wire logic so_out,
  input wire logic so_oe_n,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n
);
  wire so_line = so_oe_n ? 1'bz : so_out;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start_f();
    tick(1);
    hold_n = 1'b1;
    cs_n = 1'b0;
    tick(4);
  endtask
  // sck rests low and si toggles after select rises
  task automatic end_f();
    sck = 1'b0;
    tick(4);
    cs_n = 1'b1;
    si = ~si;
    tick(8);
  endtask
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'hZZ;
    for (int i = 7; i > 7 - n; i--) begin
      sck = 1'b0;
      si = tx[i];
      tick(4);
      sck = 1'b1;
      tick(2);
      rx[i] = so_line;
      tick(2);
    end
  endtask
  // pause moved only while sck is low
  task automatic pause(output logic oe_n_seen);
    sck = 1'b0;
    tick(4);
    hold_n = 1'b0;
    tick(6);
    oe_n_seen = so_oe_n;
    repeat (2) begin
      sck = 1'b1;
      si = ~si;
      tick(4);
      sck = 1'b0;
      tick(4);
    end
    hold_n = 1'b1;
    tick(4);
  endtask
endmodule

// ---- tb.sv ----
// self-checking bench for the serial eeprom command engine
// assumes sec_host drives the pins other than wp_n, which the bench drives, and a short programming time
`timescale 1ns/100ps
`include "sec_regs.svh"
module tb;
  import sec_pkg::*;
  localparam int PROG = 2000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic cs_n, sck, si, hold_n, so_out, so_oe_n;
  int errors = 0;
  int total_checks = 0;
  sec_byte_t exp_mem [8192];
  always #25 clk = ~clk;
  sec_spi_eeprom #(.PROG_CYCLES(PROG), .FIFO_DEPTH(8)) uut (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n));
  sec_host host (
    .clk(clk), .so_out(so_out), .so_oe_n(so_oe_n), .cs_n(cs_n),
    .sck(sck), .si(si), .hold_n(hold_n));
  task automatic chk(input string what, input sec_byte_t exp,
                     input sec_byte_t got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmd(input sec_byte_t op);
    sec_byte_t r;
    host.start_f();
    host.xfer(op, 8, r);
    host.end_f();
  endtask
  task automatic rd_sr(output sec_byte_t a, output sec_byte_t b);
    host.start_f();
    host.xfer(`SEC_OP_SRD, 8, a);
    host.xfer(8'h00, 8, a);
    host.xfer(8'h00, 8, b);
    host.end_f();
  endtask
  task automatic wait_idle();
    sec_byte_t a, b;
    for (int k = 0; k < 20; k++) begin
      rd_sr(a, b);
      if (a[0] === 1'b0) break;
    end
    chk("busy flag at idle", 8'h00, {7'h00, a[0]});
  endtask
  task automatic wr_sr(input sec_byte_t v);
    sec_byte_t r;
    cmd(`SEC_OP_SET);
    host.start_f();
    host.xfer(`SEC_OP_SWR, 8, r);
    host.xfer(v, 8, r);
    host.end_f();
    wait_idle();
  endtask
  task automatic wr_arr(input logic [15:0] a, input int n,
                        input sec_byte_t d0, input bit upd);
    sec_byte_t r;
    cmd(`SEC_OP_SET);
    host.start_f();
    host.xfer(`SEC_OP_WRITE, 8, r);
    host.xfer(a[15:8], 8, r);
    host.xfer(a[7:0], 8, r);
    for (int i = 0; i < n; i++) begin
      host.xfer(sec_byte_t'(d0 + i), 8, r);
      if (upd) begin
        exp_mem[{a[12:5], a[4:0] + 5'(i)}] = sec_byte_t'(d0 + i);
      end
    end
    host.end_f();
  endtask
  task automatic rd_arr(input logic [15:0] a, input int n, input bit bsy);
    sec_byte_t r;
    host.start_f();
    host.xfer(`SEC_OP_READ, 8, r);
    host.xfer(a[15:8], 8, r);
    host.xfer(a[7:0], 8, r);
    for (int i = 0; i < n; i++) begin
      host.xfer(8'h00, 8, r);
      chk("array byte", bsy ? 8'hZZ : exp_mem[13'(a[12:0] + i)], r);
    end
    host.end_f();
    chk("so enable after deselect", 8'h01, {7'h00, so_oe_n});
  endtask
  task automatic t_reset();
    sec_byte_t a, b;
    chk("so enable at reset", 8'h01, {7'h00, so_oe_n});
    rd_sr(a, b);
    chk("status after reset", 8'h00, a);
    $display("test reset done");
  endtask
  task automatic t_latch();
    sec_byte_t a, b, r;
    cmd(`SEC_OP_SET);
    rd_sr(a, b);
    chk("status after set", 8'h02, a);
    chk("status repeated", 8'h02, b);
    cmd(`SEC_OP_CLR);
    rd_sr(a, b);
    chk("status after clear", 8'h00, a);
    host.start_f();
    host.xfer(`SEC_OP_SET, 8, r);
    host.xfer(`SEC_OP_WRITE, 8, r);
    host.xfer(8'h00, 8, r);
    host.end_f();
    rd_sr(a, b);
    chk("set without deselect", 8'h00, a);
    host.start_f();
    host.xfer(8'hFF, 8, r);
    host.xfer(`SEC_OP_SET, 8, r);
    host.xfer(8'h00, 8, r);
    host.end_f();
    chk("so after unknown opcode", 8'hZZ, r);
    rd_sr(a, b);
    chk("status after unknown opcode", 8'h00, a);
    $display("test latch done");
  endtask
  task automatic t_page();
    sec_byte_t a, b;
    wr_arr(16'hFFFE, 4, 8'hA0, 1'b1);
    rd_sr(a, b);
    chk("status while busy", 8'h03, a);
    chk("status live while busy", 8'h03, b);
    rd_arr(16'h1FFE, 1, 1'b1);
    wait_idle();
    rd_sr(a, b);
    chk("latch after program", 8'h00, a);
    rd_arr(16'h1FFE, 2, 1'b0);
    rd_arr(16'h1FE0, 2, 1'b0);
    $display("test page done");
  endtask
  task automatic t_wrap();
    sec_byte_t r;
    logic o;
    wr_arr(16'h0000, 1, 8'h5C, 1'b1);
    wait_idle();
    host.start_f();
    host.xfer(`SEC_OP_READ, 8, r);
    host.xfer(8'h1F, 8, r);
    host.xfer(8'hFF, 8, r);
    host.xfer(8'h00, 8, r);
    chk("byte at top", exp_mem[13'h1FFF], r);
    host.pause(o);
    chk("so released in pause", 8'h01, {7'h00, o});
    host.xfer(8'h00, 8, r);
    chk("wrapped byte after pause", exp_mem[13'h0000], r);
    host.end_f();
    rd_arr(16'h1FFF, 2, 1'b0);
    $display("test wrap done");
  endtask
  task automatic t_cancel();
    sec_byte_t a, b, r;
    cmd(`SEC_OP_SET);
    host.start_f();
    host.xfer(`SEC_OP_WRITE, 8, r);
    host.xfer(8'h00, 8, r);
    host.xfer(8'h00, 8, r);
    host.xfer(8'h3C, 8, r);
    host.xfer(8'hC3, 4, r);
    host.end_f();
    rd_sr(a, b);
    chk("no program after partial byte", 8'h02, a);
    cmd(`SEC_OP_CLR);
    rd_arr(16'h0000, 1, 1'b0);
    $display("test cancel done");
  endtask
  task automatic t_protect();
    sec_byte_t a, b;
    wr_sr(8'h87);
    rd_sr(a, b);
    chk("status write result", 8'h84, a);
    wr_arr(16'h1FFF, 1, 8'h11, 1'b0);
    wait_idle();
    rd_arr(16'h1FFF, 1, 1'b0);
    wr_arr(16'h17FF, 1, 8'h22, 1'b1);
    wait_idle();
    rd_arr(16'h17FF, 1, 1'b0);
    wp_n = 1'b0;
    wr_sr(8'h00);
    rd_sr(a, b);
    chk("status write refused by pin", 8'h86, a);
    cmd(`SEC_OP_CLR);
    wp_n = 1'b1;
    wr_sr(8'h0C);
    rd_sr(a, b);
    chk("block protect all", 8'h0C, a);
    wr_arr(16'h0000, 1, 8'h33, 1'b0);
    wait_idle();
    rd_arr(16'h0000, 1, 1'b0);
    $display("test protect done");
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    t_latch();
    t_page();
    t_wrap();
    t_cancel();
    t_protect();
    results();
  end
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    $display("MISMATCH watchdog expected done seen timeout");
    results();
  end
endmodule
